/* File: bapc_cfg.svh */
`ifndef BAPC_CFG_SVH
`define BAPC_CFG_SVH
// ---------------------------------------------------------------
// constants
// ---------------------------------------------------------------
`define BAPC_PAIRS        4
`define BAPC_ADC_BITS     12
`define BAPC_DRP_AW       7
`define BAPC_DRP_DW       16
`define BAPC_DRP_TO       8'hFF
`define BAPC_ROM_ADDR_W   8
`define BAPC_DDC_ADDR     7'h50
`define BAPC_PWR_WAIT_NS  1000000
`define BAPC_CLK_NS       25
`define BAPC_PWR_WAIT_CYC ((`BAPC_PWR_WAIT_NS + `BAPC_CLK_NS - 1) / `BAPC_CLK_NS)
`define BAPC_CNT_W        16
`define BAPC_SEL_W        2
`endif

/* File: bapc_pkg.sv */
`include "bapc_cfg.svh"
package bapc_pkg;
  typedef enum logic [1:0] {
    BAPC_SD_MCU  = 2'b00,
    BAPC_SD_WAIT = 2'b01,
    BAPC_SD_ON   = 2'b10
  } bapc_sd_t;
  typedef enum logic [1:0] {
    BAPC_DRP_IDLE = 2'b00,
    BAPC_DRP_BUSY = 2'b01,
    BAPC_DRP_DONE = 2'b10
  } bapc_drp_t;
endpackage

/* File: bapc_top.sv */
`timescale 1ns/1ps
`include "bapc_cfg.svh"
module bapc_top (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  // hdmi sink port control
  input  wire logic                          sink_enable,
  input  wire logic                          ddc_slave_ready,
  output logic                               sink_buffer_tx_enable,
  output logic                               hot_plug_line,
  output logic                               hot_plug_up,
  // ddc slave pins, open drain data
  input  wire logic                          ddc_scl_in,
  input  wire logic                          ddc_sda_in,
  output logic                               ddc_sda_out,
  output logic                               ddc_sda_oe,
  output logic                               ddc_seen,
  // cec pin, open drain
  input  wire logic                          cec_pull_low,
  input  wire logic                          cec_in,
  output logic                               cec_out,
  output logic                               cec_oe,
  output logic                               cec_level,
  // microsd slot
  input  wire logic                          card_takeover,
  input  wire logic                          card_spi_mode,
  output logic                               card_slot_power_n,
  output logic                               card_ready,
  output logic                               card_mode_spi,
  // dual analog header
  input  wire logic [`BAPC_PAIRS-1:0]        pair_analog,
  input  wire logic [`BAPC_PAIRS-1:0]        pair_dig_out,
  input  wire logic [`BAPC_PAIRS-1:0]        pair_dig_drive,
  input  wire logic [`BAPC_PAIRS-1:0]        pair_dig_in,
  output logic [`BAPC_PAIRS-1:0]             pair_out,
  output logic [`BAPC_PAIRS-1:0]             pair_oe,
  output logic [`BAPC_PAIRS-1:0]             pair_in_sync,
  input  wire logic [`BAPC_SEL_W-1:0]        chan0_pair,
  input  wire logic [`BAPC_SEL_W-1:0]        chan1_pair,
  output logic [`BAPC_PAIRS-1:0]             chan0_route,
  output logic [`BAPC_PAIRS-1:0]             chan1_route,
  // reconfig port user side
  input  wire logic                          rd_req,
  input  wire logic                          wr_req,
  input  wire logic [`BAPC_DRP_AW-1:0]       req_addr,
  input  wire logic [`BAPC_DRP_DW-1:0]       req_wdata,
  output logic                               req_busy,
  output logic                               req_done,
  output logic                               req_timeout,
  output logic [`BAPC_DRP_DW-1:0]            req_rdata,
  output logic [`BAPC_ADC_BITS-1:0]          sample_data,
  // reconfig port converter side
  output logic                               reconfig_port_en,
  output logic                               reconfig_port_we,
  output logic [`BAPC_DRP_AW-1:0]            reconfig_port_addr,
  output logic [`BAPC_DRP_DW-1:0]            reconfig_port_di,
  input  wire logic [`BAPC_DRP_DW-1:0]       reconfig_port_do,
  input  wire logic                          reconfig_port_rdy
);
  import bapc_pkg::*;

  // one-hot route of a channel selection, zero when the selected pair is not analog
  function automatic logic [`BAPC_PAIRS-1:0] sel_route(input logic [`BAPC_SEL_W-1:0] s,
                                                      input logic [`BAPC_PAIRS-1:0] an);
    sel_route = an & (`BAPC_PAIRS'(1) << s);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  logic [`BAPC_PAIRS+3:0] s1_r, s2_r, s3_r, pin_r;
  logic [`BAPC_PAIRS+3:0] s1_nxt, s2_nxt, s3_nxt, pin_nxt;
  always_comb begin
    s1_nxt  = {ddc_scl_in, ddc_sda_in, cec_in, 1'b0, pair_dig_in};
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    pin_nxt = pin_r;
    for (int i = 0; i < `BAPC_PAIRS + 4; i++) begin
      if (s2_r[i] == s3_r[i]) pin_nxt[i] = s3_r[i];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_r  <= '1;
      s2_r  <= '1;
      s3_r  <= '1;
      pin_r <= '1;
    end else begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      s3_r  <= s3_nxt;
      pin_r <= pin_nxt;
    end
  end

  // ---------------------------------------------------------------
  // hdmi sink port: buffer enable, hot plug, ddc activity
  // ---------------------------------------------------------------
  // hot plug waits for the ddc slave, because a source reads
  // capabilities first and would get garbage otherwise
  logic sink_buffer_tx_enable_r, sink_buffer_tx_enable_nxt, hpa_r, hpa_nxt, ddc_r, ddc_nxt, scl_d_r, scl_d_nxt;
  always_comb begin
    sink_buffer_tx_enable_nxt  = sink_enable;
    hpa_nxt   = sink_enable & ddc_slave_ready;
    scl_d_nxt = pin_r[`BAPC_PAIRS+3];
    ddc_nxt   = ddc_r;
    // first scl clock from the source marks its capability query
    if (!hpa_r) ddc_nxt = 1'b0;
    else if (scl_d_r && !pin_r[`BAPC_PAIRS+3]) ddc_nxt = 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sink_buffer_tx_enable_r  <= 1'b0;
      hpa_r   <= 1'b0;
      ddc_r   <= 1'b0;
      scl_d_r <= 1'b1;
    end else begin
      sink_buffer_tx_enable_r  <= sink_buffer_tx_enable_nxt;
      hpa_r   <= hpa_nxt;
      ddc_r   <= ddc_nxt;
      scl_d_r <= scl_d_nxt;
    end
  end
  assign sink_buffer_tx_enable = sink_buffer_tx_enable_r;
  assign hot_plug_line         = hpa_r;
  assign hot_plug_up           = hpa_r;
  assign ddc_seen              = ddc_r;
  // we never master ddc: scl is input only, sda only pulled low
  // by the slave logic outside, through ddc_slave_ready path
  assign ddc_sda_out           = 1'b0;
  assign ddc_sda_oe            = 1'b0;

  // ---------------------------------------------------------------
  // cec open drain
  // ---------------------------------------------------------------
  logic cec_r, cec_nxt;
  always_comb cec_nxt = cec_pull_low;
  always_ff @(posedge clk_sys) begin
    if (!rstn) cec_r <= 1'b0;
    else       cec_r <= cec_nxt;
  end
  assign cec_out   = 1'b0;                       // never drives high
  assign cec_oe    = cec_r;
  assign cec_level = pin_r[`BAPC_PAIRS+1];

  // ---------------------------------------------------------------
  // microsd slot handover and power
  // ---------------------------------------------------------------
  // slot power wait is an own margin before the card is usable
  localparam logic [`BAPC_CNT_W-1:0] PWR_CYC = `BAPC_CNT_W'(`BAPC_PWR_WAIT_CYC);
  bapc_sd_t              sd_r, sd_nxt;
  logic [`BAPC_CNT_W-1:0] sd_cnt_r, sd_cnt_nxt;
  logic                  spi_r, spi_nxt;
  always_comb begin
    sd_nxt     = sd_r;
    sd_cnt_nxt = sd_cnt_r;
    spi_nxt    = spi_r;
    case (sd_r)
      BAPC_SD_MCU: begin
        // mcu has released the slot unpowered once we run
        if (card_takeover) begin
          sd_nxt     = BAPC_SD_WAIT;
          sd_cnt_nxt = PWR_CYC;
        end
      end
      BAPC_SD_WAIT: begin
        if (!card_takeover) sd_nxt = BAPC_SD_MCU;
        else if (sd_cnt_r <= `BAPC_CNT_W'(1)) sd_nxt = BAPC_SD_ON;
        else sd_cnt_nxt = sd_cnt_r - `BAPC_CNT_W'(1);
      end
      BAPC_SD_ON: begin
        if (!card_takeover) sd_nxt = BAPC_SD_MCU;
      end
      default: sd_nxt = BAPC_SD_MCU;
    endcase
    // mode latches only while the card is not in use
    if (sd_r != BAPC_SD_ON) spi_nxt = card_spi_mode;
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sd_r     <= BAPC_SD_MCU;
      sd_cnt_r <= '0;
      spi_r    <= 1'b0;
    end else begin
      sd_r     <= sd_nxt;
      sd_cnt_r <= sd_cnt_nxt;
      spi_r    <= spi_nxt;
    end
  end
  assign card_slot_power_n = (sd_r == BAPC_SD_MCU);   // low powers slot
  assign card_ready        = (sd_r == BAPC_SD_ON);
  assign card_mode_spi     = spi_r;

  // ---------------------------------------------------------------
  // dual analog header pairs and channel routing
  // ---------------------------------------------------------------
  // analog pairs are never driven, or the filter input would fight
  logic [`BAPC_PAIRS-1:0] po_r, po_nxt, poe_r, poe_nxt, r0_r, r0_nxt, r1_r, r1_nxt;
  always_comb begin
    po_nxt  = pair_dig_out & ~pair_analog;
    poe_nxt = pair_dig_drive & ~pair_analog;
    r0_nxt  = sel_route(chan0_pair, pair_analog);
    r1_nxt  = sel_route(chan1_pair, pair_analog);
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      po_r  <= '0;
      poe_r <= '0;
      r0_r  <= '0;
      r1_r  <= '0;
    end else begin
      po_r  <= po_nxt;
      poe_r <= poe_nxt;
      r0_r  <= r0_nxt;
      r1_r  <= r1_nxt;
    end
  end
  assign pair_out     = po_r;
  assign pair_oe      = poe_r;
  assign pair_in_sync = pin_r[`BAPC_PAIRS-1:0] & ~pair_analog;
  assign chan0_route  = r0_r;
  assign chan1_route  = r1_r;

  // ---------------------------------------------------------------
  // reconfig port master
  // ---------------------------------------------------------------
  // one access at a time; a timeout stops a dead port hanging us
  bapc_drp_t               dr_r, dr_nxt;
  logic                    en_r, en_nxt, we_r, we_nxt, to_r, to_nxt;
  logic [`BAPC_DRP_AW-1:0] ad_r, ad_nxt;
  logic [`BAPC_DRP_DW-1:0] di_r, di_nxt, rd_r, rd_nxt;
  logic [7:0]              tc_r, tc_nxt;
  always_comb begin
    dr_nxt = dr_r;
    en_nxt = 1'b0;
    we_nxt = 1'b0;
    ad_nxt = ad_r;
    di_nxt = di_r;
    rd_nxt = rd_r;
    to_nxt = to_r;
    tc_nxt = tc_r;
    case (dr_r)
      BAPC_DRP_IDLE: begin
        if (rd_req || wr_req) begin
          dr_nxt = BAPC_DRP_BUSY;
          en_nxt = 1'b1;
          we_nxt = wr_req;
          ad_nxt = req_addr;
          di_nxt = req_wdata;
          tc_nxt = `BAPC_DRP_TO;
          to_nxt = 1'b0;
        end
      end
      BAPC_DRP_BUSY: begin
        if (reconfig_port_rdy) begin
          rd_nxt = reconfig_port_do;
          dr_nxt = BAPC_DRP_DONE;
        end else if (tc_r == 8'h00) begin
          to_nxt = 1'b1;
          dr_nxt = BAPC_DRP_DONE;
        end else tc_nxt = tc_r - 8'h01;
      end
      BAPC_DRP_DONE: dr_nxt = BAPC_DRP_IDLE;
      default:       dr_nxt = BAPC_DRP_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dr_r <= BAPC_DRP_IDLE;
      en_r <= 1'b0;
      we_r <= 1'b0;
      ad_r <= '0;
      di_r <= '0;
      rd_r <= '0;
      to_r <= 1'b0;
      tc_r <= 8'h00;
    end else begin
      dr_r <= dr_nxt;
      en_r <= en_nxt;
      we_r <= we_nxt;
      ad_r <= ad_nxt;
      di_r <= di_nxt;
      rd_r <= rd_nxt;
      to_r <= to_nxt;
      tc_r <= tc_nxt;
    end
  end
  assign reconfig_port_en   = en_r;
  assign reconfig_port_we   = we_r;
  assign reconfig_port_addr = ad_r;
  assign reconfig_port_di   = di_r;
  assign req_busy           = (dr_r != BAPC_DRP_IDLE);
  assign req_done           = (dr_r == BAPC_DRP_DONE);
  assign req_timeout        = to_r;
  assign req_rdata          = rd_r;
  // results are left justified: 12 bits in the top of the word
  assign sample_data        = rd_r[`BAPC_DRP_DW-1 -: `BAPC_ADC_BITS];
endmodule // bapc_top

/* File: bapc_conv_model.sv */
`timescale 1ns/1ps
`include "bapc_cfg.svh"
// converter behind the reconfig port; lag 8'hFF never answers
module bapc_conv_model (
  // converter side pins
  input  wire logic                     clk_sys,
  input  wire logic                     en,
  input  wire logic                     we,
  input  wire logic [`BAPC_DRP_AW-1:0]  addr,
  input  wire logic [`BAPC_DRP_DW-1:0]  di,
  input  wire logic [7:0]               lag,
  output logic      [`BAPC_DRP_DW-1:0]  dout,
  output logic                          rdy
);
  logic [`BAPC_DRP_DW-1:0] mem [0:127];
  logic [`BAPC_DRP_AW-1:0] a_q;
  int                      cnt = -1;
  initial rdy = 1'h0;
  initial dout = 16'h0;
  // data lines toggle outside answers so stale data never looks valid
  always @(posedge clk_sys) begin
    rdy <= 1'h0;
    dout <= ~dout;
    if (en) begin
      a_q <= addr;
      cnt <= (lag == 8'hFF) ? -1 : int'(lag);
      if (we) mem[addr] <= di;
    end else if (cnt == 0) begin
      rdy <= 1'h1;
      dout <= mem[a_q];
      cnt <= -1;
    end else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule // bapc_conv_model

/* File: bapc_asserts.sv */
`timescale 1ns/1ps
module bapc_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // hdmi, cec, card
  input wire logic sink_enable,
  input wire logic ddc_slave_ready,
  input wire logic sink_buffer_tx_enable,
  input wire logic hot_plug_line,
  input wire logic cec_pull_low,
  input wire logic cec_oe,
  input wire logic cec_out,
  input wire logic card_takeover,
  input wire logic card_slot_power_n,
  // reconfig port
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic req_busy,
  input wire logic req_done,
  input wire logic reconfig_port_en,
  input wire logic reconfig_port_rdy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_take; (rd_req || wr_req) && !req_busy; endsequence
  sequence s_answer; reconfig_port_rdy && req_busy; endsequence
  property p_sink_buffer_tx_enable; sink_enable |=> sink_buffer_tx_enable; endproperty
  a_sink_buffer_tx_enable: assert property (p_sink_buffer_tx_enable) else $error("tx enable late");
  property p_hpd_gate; !ddc_slave_ready |=> !hot_plug_line; endproperty
  a_hpd_gate: assert property (p_hpd_gate) else $error("hot plug early");
  property p_hpd_rise; $rose(hot_plug_line) |-> $past(ddc_slave_ready && sink_enable); endproperty
  a_hpd_rise: assert property (p_hpd_rise) else $error("hot plug rose");
  property p_cec_od; cec_oe |-> !cec_out; endproperty
  a_cec_od: assert property (p_cec_od) else $error("cec driven high");
  property p_cec_oe; cec_pull_low |=> cec_oe; endproperty
  a_cec_oe: assert property (p_cec_oe) else $error("cec not pulled");
  property p_power; $past(rstn) |-> card_slot_power_n != $past(card_takeover); endproperty
  a_power: assert property (p_power) else $error("slot power wrong");
  property p_take; s_take |=> reconfig_port_en ##1 !reconfig_port_en; endproperty
  a_take: assert property (p_take) else $error("port enable wrong");
  property p_done; s_answer |=> req_done ##1 !req_done; endproperty
  a_done: assert property (p_done) else $error("done wrong");
  property p_rst;
    disable iff (1'b0) !rstn |=> !hot_plug_line && !sink_buffer_tx_enable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs high");
endmodule // bapc_asserts
bind bapc_top bapc_asserts u_bapc_asserts (.clk_sys(clk_sys), .rstn(rstn),
  .sink_enable(sink_enable), .ddc_slave_ready(ddc_slave_ready),
  .sink_buffer_tx_enable(sink_buffer_tx_enable), .hot_plug_line(hot_plug_line),
  .cec_pull_low(cec_pull_low), .cec_oe(cec_oe), .cec_out(cec_out),
  .card_takeover(card_takeover), .card_slot_power_n(card_slot_power_n),
  .rd_req(rd_req), .wr_req(wr_req), .req_busy(req_busy), .req_done(req_done),
  .reconfig_port_en(reconfig_port_en), .reconfig_port_rdy(reconfig_port_rdy));

/* File: bapc_top_tb.sv */
`timescale 1ns/1ps
module bapc_top_tb;
  logic        clk_sys = 1'h0, rstn = 1'h0, sink_enable = 1'h0, ddc_slave_ready = 1'h0;
  logic        ddc_scl_in = 1'h1, ddc_sda_in = 1'h1, cec_pull_low = 1'h0, cec_other = 1'h0;
  logic        card_takeover = 1'h0, card_spi_mode = 1'h0, rd_req = 1'h0, wr_req = 1'h0;
  logic        sink_buffer_tx_enable, hot_plug_line, hot_plug_up, ddc_sda_out, ddc_sda_oe;
  logic        ddc_seen, cec_in, cec_out, cec_oe, cec_level, card_slot_power_n, card_ready;
  logic        card_mode_spi, req_busy, req_done, req_timeout;
  logic        reconfig_port_en, reconfig_port_we, reconfig_port_rdy;
  logic [3:0]  pair_analog = 4'h0, pair_dig_out = 4'h0, pair_dig_drive = 4'h0;
  logic [3:0]  pair_dig_in = 4'h0, pair_out, pair_oe, pair_in_sync, chan0_route, chan1_route;
  logic [1:0]  chan0_pair = 2'h0, chan1_pair = 2'h0;
  logic [6:0]  req_addr = 7'h0, reconfig_port_addr;
  logic [15:0] req_wdata = 16'h0, req_rdata, reconfig_port_di, reconfig_port_do;
  logic [11:0] sample_data;
  logic [7:0]  lag = 8'h0;
  int          n_mismatch = 0, num_checks = 0;
  // cec wire: pull-up, low when either party pulls
  assign cec_in = !(cec_oe && !cec_out) && !cec_other;
  always #12.5 clk_sys = ~clk_sys;
  bapc_top u_bapc_top (.clk_sys(clk_sys), .rstn(rstn), .sink_enable(sink_enable),
    .ddc_slave_ready(ddc_slave_ready), .sink_buffer_tx_enable(sink_buffer_tx_enable),
    .hot_plug_line(hot_plug_line), .hot_plug_up(hot_plug_up), .ddc_scl_in(ddc_scl_in),
    .ddc_sda_in(ddc_sda_in), .ddc_sda_out(ddc_sda_out), .ddc_sda_oe(ddc_sda_oe),
    .ddc_seen(ddc_seen), .cec_pull_low(cec_pull_low), .cec_in(cec_in), .cec_out(cec_out),
    .cec_oe(cec_oe), .cec_level(cec_level), .card_takeover(card_takeover),
    .card_spi_mode(card_spi_mode), .card_slot_power_n(card_slot_power_n),
    .card_ready(card_ready), .card_mode_spi(card_mode_spi), .pair_analog(pair_analog),
    .pair_dig_out(pair_dig_out), .pair_dig_drive(pair_dig_drive),
    .pair_dig_in(pair_dig_in), .pair_out(pair_out), .pair_oe(pair_oe),
    .pair_in_sync(pair_in_sync), .chan0_pair(chan0_pair), .chan1_pair(chan1_pair),
    .chan0_route(chan0_route), .chan1_route(chan1_route), .rd_req(rd_req),
    .wr_req(wr_req), .req_addr(req_addr), .req_wdata(req_wdata), .req_busy(req_busy),
    .req_done(req_done), .req_timeout(req_timeout), .req_rdata(req_rdata),
    .sample_data(sample_data), .reconfig_port_en(reconfig_port_en),
    .reconfig_port_we(reconfig_port_we), .reconfig_port_addr(reconfig_port_addr),
    .reconfig_port_di(reconfig_port_di), .reconfig_port_do(reconfig_port_do),
    .reconfig_port_rdy(reconfig_port_rdy));
  bapc_conv_model u_bapc_conv_model (.clk_sys(clk_sys), .en(reconfig_port_en),
    .we(reconfig_port_we), .addr(reconfig_port_addr), .di(reconfig_port_di),
    .lag(lag), .dout(reconfig_port_do), .rdy(reconfig_port_rdy));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one port access, raised while idle, then wait for done or timeout
  task automatic reconfig_port(logic wr, logic [6:0] a, logic [15:0] d, logic to);
    int k;
    k = 0;
    req_addr = a;
    req_wdata = d;
    wr_req = wr;
    rd_req = !wr;
    cyc(1);
    rd_req = 1'h0;
    wr_req = 1'h0;
    chk("busy", 1'h1, req_busy);
    while (req_done !== 1'h1 && req_timeout !== 1'h1 && k < 300) begin
      cyc(1);
      k++;
    end
    chk("done", 1'h1, req_done);
    chk("timeout", to, req_timeout);
    cyc(1);
    chk("done_pulse", 1'h0, req_done);
    chk("idle", 1'h0, req_busy);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog well beyond the card power wait
  initial begin
    cyc(60000);
    n_mismatch++;
    print_verdict;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int k;
    k = 0;
    cyc(8);
    chk("hpd_rst", 1'h0, hot_plug_line);
    chk("sink_buffer_tx_enable_rst", 1'h0, sink_buffer_tx_enable);
    chk("pwr_rst", 1'h1, card_slot_power_n);
    rstn = 1'h1;
    sink_enable = 1'h1;
    cyc(2);
    chk("sink_buffer_tx_enable", 1'h1, sink_buffer_tx_enable);
    chk("hpd_early", 1'h0, hot_plug_line);
    ddc_slave_ready = 1'h1;
    cyc(2);
    chk("hpd", 1'h1, hot_plug_line);
    chk("hpu", 1'h1, hot_plug_up);
    chk("ddc_idle", 1'h0, ddc_seen);
    ddc_scl_in = 1'h0;
    cyc(6);
    chk("ddc_seen", 1'h1, ddc_seen);
    chk("sda_oe", 1'h0, ddc_sda_oe);
    chk("sda_out", 1'h0, ddc_sda_out);
    ddc_slave_ready = 1'h0;
    cyc(3);
    chk("hpd_off", 1'h0, hot_plug_line);
    chk("ddc_clr", 1'h0, ddc_seen);
    cec_pull_low = 1'h1;
    cyc(2);
    chk("cec_oe", 1'h1, cec_oe);
    chk("cec_out", 1'h0, cec_out);
    cec_pull_low = 1'h0;
    cec_other = 1'h1;
    cyc(5);
    chk("cec_lvl", 1'h0, cec_level);
    cec_other = 1'h0;
    cyc(5);
    chk("cec_rel", 1'h0, cec_oe);
    chk("cec_lvl_hi", 1'h1, cec_level);
    pair_analog = 4'h5;
    pair_dig_drive = 4'hF;
    pair_dig_out = 4'hF;
    pair_dig_in = 4'hF;
    chan0_pair = 2'h2;
    chan1_pair = 2'h1;
    cyc(5);
    chk("pair_oe", 4'hA, pair_oe);
    chk("pair_out", 4'hA, pair_out);
    chk("pair_in", 4'hA, pair_in_sync);
    chk("route0", 4'h4, chan0_route);
    chk("route1", 4'h0, chan1_route);
    pair_analog = 4'hA;
    cyc(5);
    chk("pair_oe2", 4'h5, pair_oe);
    chk("route1b", 4'h2, chan1_route);
    reconfig_port(1'h1, 7'h10, 16'h1234, 1'h0);
    lag = 8'h09;
    reconfig_port(1'h0, 7'h10, 16'h0, 1'h0);
    chk("rdata", 16'h1234, req_rdata);
    chk("sample", 12'h123, sample_data);
    lag = 8'hFF;
    reconfig_port(1'h0, 7'h10, 16'h0, 1'h1);
    lag = 8'h00;
    reconfig_port(1'h1, 7'h20, 16'h5A5C, 1'h0);
    reconfig_port(1'h0, 7'h10, 16'h0, 1'h0);
    chk("rdata2", 16'h1234, req_rdata);
    card_spi_mode = 1'h1;
    card_takeover = 1'h1;
    cyc(2);
    chk("pwr_on", 1'h0, card_slot_power_n);
    chk("rdy_early", 1'h0, card_ready);
    while (card_ready !== 1'h1 && k < 40100) begin
      cyc(1);
      k++;
    end
    chk("card_rdy", 1'h1, card_ready);
    chk("wait_len", 1'h1, k > 39990);
    card_spi_mode = 1'h0;
    cyc(2);
    chk("spi_mode", 1'h1, card_mode_spi);
    card_takeover = 1'h0;
    cyc(2);
    chk("pwr_off", 1'h1, card_slot_power_n);
    chk("rdy_off", 1'h0, card_ready);
    chk("native", 1'h0, card_mode_spi);
    print_verdict;
  end
endmodule // bapc_top_tb
